/* hdl/led_status_pkg.sv */
// Purpose : constants for the network status LED block
// Assumes : 16-bit registers on a plain strobe port, 100 MHz clock
// Notes   : offsets are register indices, one per word
//
// Summary of operation
// - link bit reads one when link LED lit
// - mask link LED when any LED enables full-duplex link, on twisted pair with duplex enable set, attachment duplex clear
// - link register low bits written zero, undefined
// - first LED shows OR of enabled functions
// - first LED resets to receive, stretch on
// - bit 15 shows unstretched OR of functions
// - wake enable lights LED after wake packet
// - twisted pair: link pass and duplex enable
// - attachment port: duplex enable and its duplex
// - serial port: duplex enable alone
// - bit 7 enables pulse stretching
// - reserved bit 6 reads and writes zero
// - bit 5 limits receive to address matches
// - bit 4 adds transmit activity
// - bit 3 adds good receive polarity
// - bit 2 adds receive activity
// - bit 1 adds jabber condition
// - bit 0 adds collision activity
// - second LED resets to polarity, stretch on
// - bit 14 sets second LED active level
// - second LED pin level follows polarity table
package led_status_pkg;

    // *************************************************
    // register indices
    // *************************************************
    localparam logic [3:0] REG_LINK_STATUS = 4'h0; // link status, read only
    localparam logic [3:0] REG_FIRST_ACTIVITY_PIN_SEL    = 4'h1; // first LED selector
    localparam logic [3:0] REG_SECOND_ACTIVITY_PIN_SEL    = 4'h2; // second LED selector
    localparam logic [3:0] REG_DUPLEX_CFG  = 4'h3; // duplex configuration

    // *************************************************
    // selector field positions
    // *************************************************
    localparam int BIT_OUT_STATE = 15; // unstretched state, read only
    localparam int BIT_INVERT    = 14; // second LED only
    localparam int BIT_WAKE      = 9;
    localparam int BIT_FDLS      = 8;
    localparam int BIT_PSE       = 7;
    localparam int BIT_ADDR_M    = 5;
    localparam int BIT_XMT       = 4;
    localparam int BIT_POL       = 3;
    localparam int BIT_RCV       = 2;
    localparam int BIT_JAB       = 1;
    localparam int BIT_COL       = 0;
    localparam int BIT_LINK_GOOD = 15; // in link status register
    localparam int BIT_DUP_EN    = 0;  // in duplex configuration
    localparam int BIT_AUI_DUP   = 1;

    // *************************************************
    // writable masks and reset values
    // *************************************************
    localparam logic [15:0] FIRST_ACTIVITY_PIN_WR_MASK = 16'h03bf;
    localparam logic [15:0] SECOND_ACTIVITY_PIN_WR_MASK = 16'h43bf;
    localparam logic [15:0] DUP_WR_MASK  = 16'h0003;
    localparam logic [15:0] FIRST_ACTIVITY_PIN_RESET   = 16'h0084;
    localparam logic [15:0] SECOND_ACTIVITY_PIN_RESET   = 16'h0088;
    localparam logic [15:0] DUP_RESET    = 16'h0000;

    // *************************************************
    // port selection and timing
    // *************************************************
    typedef enum logic [1:0] {
        PORT_TP   = 2'h0,
        PORT_AUI  = 2'h1,
        PORT_GENERAL_SERIAL_PORT = 2'h2
    } port_sel_t;

    localparam int CLK_MHZ        = 100;
    localparam int STRETCH_TIME_US = 100; // led on-time after last event
    localparam int STRETCH_CYCLES = STRETCH_TIME_US * CLK_MHZ;
    localparam int CNT_W          = 16;

endpackage : led_status_pkg

/* hdl/led_stretch.sv */
// Purpose : pulse stretcher for one LED function
// Assumes : function input is synchronous to i_ref_clk
// Notes   : output is a flip-flop
`timescale 1ns/1ps
module led_stretch #(
    parameter int unsigned HOLD = 100
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // function in
    input  wire logic i_func,
    input  wire logic i_enable,
    // stretched out
    output logic      o_led
);

    logic [led_status_pkg::CNT_W-1:0] cnt_q; // remaining hold cycles
    logic [led_status_pkg::CNT_W-1:0] cnt_d;
    logic                             led_d;

    // *************************************************
    // hold counter
    // *************************************************
    // reload on every occurrence, run down afterwards
    assign cnt_d = (i_func && i_enable) ? led_status_pkg::CNT_W'(HOLD) :
                   (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    // stretching off clears the hold at once
    assign led_d = i_func || (i_enable && cnt_q != '0);

    // state register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
            o_led <= 1'b0;
        end else begin
            cnt_q <= i_enable ? cnt_d : '0;
            o_led <= led_d;
        end
    end

endmodule : led_stretch

/* hdl/led_status_ctrl.sv */
// Purpose : status LED control: link LED and two selectable activity LEDs
// Assumes : network status inputs come from logic on i_ref_clk
// Notes   : pins are active low except second LED when inverted
`timescale 1ns/1ps
module led_status_ctrl #(
    parameter int unsigned STRETCH_CYCLES = led_status_pkg::STRETCH_CYCLES
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wr_data,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    output logic      [15:0] o_rd_data,
    // network status, same clock domain
    input  wire logic [1:0]  i_port_sel,
    input  wire logic        i_link_pass,
    input  wire logic        i_rx_act,
    input  wire logic        i_rx_addr_match,
    input  wire logic        i_tx_act,
    input  wire logic        i_rx_pol_good,
    input  wire logic        i_jabber,
    input  wire logic        i_collision,
    input  wire logic        i_wake_rx,
    input  wire logic        i_led3_fdls_en,
    // led pins
    output logic             o_link_indicator_pin_n,
    output logic             o_first_activity_pin_n,
    output logic             o_second_activity_pin
);

    // *************************************************
    // registers and wires
    // *************************************************
    logic [15:0] sel_q [2];      // led selectors, index 0 first
    logic [15:0] dup_q;          // duplex configuration
    logic [15:0] rd_data_d;      // read mux result
    logic        wake_seen_q;    // wake packet received
    logic        func [2];       // unstretched OR per led
    logic        led_on [2];     // stretched state per led
    logic        link_on;        // link indicator asserted
    logic        link_mask;      // link indicator masked
    logic        fdl_status;     // full-duplex link function
    logic        any_fdls;       // any selector shows duplex link
    logic        dup_en;         // duplex enable bit
    logic        aui_dup;        // attachment port duplex bit
    logic        port_tp;        // twisted pair active
    logic        port_aui;       // attachment port active
    logic        port_general_serial_port;      // serial port active
    logic        wr_first_activity_pin;        // write decode
    logic        wr_second_activity_pin;
    logic        wr_dup;
    logic        wake_clr;       // wake latch clear request
    logic        link_pin_d;     // pin next values
    logic        first_activity_pin_pin_d;
    logic        second_activity_pin_pin_d;

    // *************************************************
    // decode
    // *************************************************
    assign wr_first_activity_pin   = i_wr_en && (i_addr == led_status_pkg::REG_FIRST_ACTIVITY_PIN_SEL);
    assign wr_second_activity_pin   = i_wr_en && (i_addr == led_status_pkg::REG_SECOND_ACTIVITY_PIN_SEL);
    assign wr_dup    = i_wr_en && (i_addr == led_status_pkg::REG_DUPLEX_CFG);
    assign dup_en    = dup_q[led_status_pkg::BIT_DUP_EN];
    assign aui_dup   = dup_q[led_status_pkg::BIT_AUI_DUP];
    assign port_tp   = (i_port_sel == led_status_pkg::PORT_TP);
    assign port_aui  = (i_port_sel == led_status_pkg::PORT_AUI);
    assign port_general_serial_port = (i_port_sel == led_status_pkg::PORT_GENERAL_SERIAL_PORT);

    // *************************************************
    // full-duplex link function
    // *************************************************
    // one status shared by every selector that enables it
    assign fdl_status = (port_tp && i_link_pass && dup_en)
                     || (port_aui && dup_en && aui_dup)
                     || (port_general_serial_port && dup_en);

    // *************************************************
    // link indicator
    // *************************************************
    assign any_fdls  = sel_q[0][led_status_pkg::BIT_FDLS]
                    || sel_q[1][led_status_pkg::BIT_FDLS]
                    || i_led3_fdls_en;
    // lets a board show half and full duplex links on separate LEDs
    assign link_mask = port_tp && dup_en && !aui_dup && any_fdls;
    assign link_on   = i_link_pass && !link_mask;

    // *************************************************
    // per-led function OR
    // *************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_led
            logic rx_qual; // receive activity after address filter
            // address filter only narrows receive indications
            assign rx_qual = i_rx_act
                && (!sel_q[g][led_status_pkg::BIT_ADDR_M] || i_rx_addr_match);
            // several sources may be on together
            assign func[g] =
                   (sel_q[g][led_status_pkg::BIT_WAKE] && wake_seen_q)
                || (sel_q[g][led_status_pkg::BIT_FDLS] && fdl_status)
                || (sel_q[g][led_status_pkg::BIT_XMT]  && i_tx_act)
                || (sel_q[g][led_status_pkg::BIT_POL]  && i_rx_pol_good)
                || (sel_q[g][led_status_pkg::BIT_RCV]  && rx_qual)
                || (sel_q[g][led_status_pkg::BIT_JAB]  && i_jabber)
                || (sel_q[g][led_status_pkg::BIT_COL]  && i_collision);

            // stretcher per led
            led_stretch #(
                .HOLD     (STRETCH_CYCLES)
            ) u_stretch (
                .i_ref_clk(i_ref_clk),
                .i_rst    (i_rst),
                .i_func   (func[g]),
                .i_enable (sel_q[g][led_status_pkg::BIT_PSE]),
                .o_led    (led_on[g])
            );
        end
    endgenerate

    // *************************************************
    // selector and configuration registers
    // *************************************************
    // writes keep only writable bits, reserved stay zero
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_q[0] <= led_status_pkg::FIRST_ACTIVITY_PIN_RESET;
            sel_q[1] <= led_status_pkg::SECOND_ACTIVITY_PIN_RESET;
            dup_q    <= led_status_pkg::DUP_RESET;
        end else begin
            if (wr_first_activity_pin) begin
                sel_q[0] <= i_wr_data & led_status_pkg::FIRST_ACTIVITY_PIN_WR_MASK;
            end
            if (wr_second_activity_pin) begin
                sel_q[1] <= i_wr_data & led_status_pkg::SECOND_ACTIVITY_PIN_WR_MASK;
            end
            if (wr_dup) begin
                dup_q <= i_wr_data & led_status_pkg::DUP_WR_MASK;
            end
        end
    end

    // *************************************************
    // wake packet latch
    // *************************************************
    // cleared when no selector enables it any longer
    assign wake_clr = !sel_q[0][led_status_pkg::BIT_WAKE]
                   && !sel_q[1][led_status_pkg::BIT_WAKE];

    // set wins over clear so no packet is lost
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_seen_q <= 1'b0;
        end else if (i_wake_rx) begin
            wake_seen_q <= 1'b1;
        end else if (wake_clr) begin
            wake_seen_q <= 1'b0;
        end
    end

    // *************************************************
    // read mux
    // *************************************************
    // link register low bits read as zero, software must not rely on it
    always_comb begin
        rd_data_d = 16'h0000;
        case (i_addr)
            led_status_pkg::REG_LINK_STATUS: begin
                rd_data_d[led_status_pkg::BIT_LINK_GOOD] = link_on;
            end
            led_status_pkg::REG_FIRST_ACTIVITY_PIN_SEL: begin
                rd_data_d = sel_q[0];
                rd_data_d[led_status_pkg::BIT_OUT_STATE] = func[0];
            end
            led_status_pkg::REG_SECOND_ACTIVITY_PIN_SEL: begin
                rd_data_d = sel_q[1];
                rd_data_d[led_status_pkg::BIT_OUT_STATE] = func[1];
            end
            led_status_pkg::REG_DUPLEX_CFG: begin
                rd_data_d = dup_q;
            end
            default: begin
                rd_data_d = 16'h0000; // unmapped reads zero
            end
        endcase
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= 16'h0000;
        end else begin
            o_rd_data <= i_rd_en ? rd_data_d : 16'h0000;
        end
    end

    // *************************************************
    // pin drivers
    // *************************************************
    assign link_pin_d = !link_on;
    assign first_activity_pin_pin_d = !led_on[0];
    // invert set: active high; clear: active low
    assign second_activity_pin_pin_d = sel_q[1][led_status_pkg::BIT_INVERT] ? led_on[1] : !led_on[1];

    // pins straight from flip-flops, all dark in reset
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_link_indicator_pin_n <= 1'b1;
            o_first_activity_pin_n <= 1'b1;
            o_second_activity_pin  <= 1'b1;
        end else begin
            o_link_indicator_pin_n <= link_pin_d;
            o_first_activity_pin_n <= first_activity_pin_pin_d;
            o_second_activity_pin  <= second_activity_pin_pin_d;
        end
    end

    // *************************************************
    // checks
    // *************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // read strobe for a given register
    sequence s_rd_link;
        i_rd_en && i_addr == led_status_pkg::REG_LINK_STATUS;
    endsequence
    sequence s_rd_first_activity_pin;
        i_rd_en && i_addr == led_status_pkg::REG_FIRST_ACTIVITY_PIN_SEL;
    endsequence
    // read strobe on the second selector
    sequence s_rd_second_activity_pin;
        i_rd_en && i_addr == led_status_pkg::REG_SECOND_ACTIVITY_PIN_SEL;
    endsequence
    // function quiet with stretch off for two cycles
    sequence s_first_activity_pin_quiet;
        (!sel_q[0][led_status_pkg::BIT_PSE] && !func[0])[*2];
    endsequence

    chk_link_read_bit: assert property (
        s_rd_link |=> o_rd_data[15] == $past(link_on) && o_rd_data[14:0] == 15'h0000)
        else $error("link status bit wrong");
    chk_link_mask_dark: assert property (
        link_mask |=> o_link_indicator_pin_n)
        else $error("link LED not masked");
    chk_first_activity_pin_rsvd_zero: assert property (
        s_rd_first_activity_pin |=> !o_rd_data[6] && o_rd_data[14:10] == 5'h00)
        else $error("reserved bits not zero");
    chk_first_activity_pin_state_bit: assert property (
        s_rd_first_activity_pin |=> o_rd_data[15] == $past(func[0]))
        else $error("output state bit wrong");
    chk_tx_lights_led: assert property (
        sel_q[0][led_status_pkg::BIT_XMT] && i_tx_act |=> ##1 !o_first_activity_pin_n)
        else $error("transmit activity not shown");
    chk_aui_fdl_func: assert property (
        port_aui && dup_en && aui_dup && sel_q[0][led_status_pkg::BIT_FDLS] |-> func[0])
        else $error("attachment duplex link not shown");
    chk_general_serial_port_fdl_off: assert property (
        port_general_serial_port && !dup_en |-> !fdl_status)
        else $error("serial duplex link wrong");
    chk_no_stretch_off: assert property (
        s_first_activity_pin_quiet |=> o_first_activity_pin_n)
        else $error("led lit with stretch off");
    chk_stretch_holds: assert property (
        sel_q[0][led_status_pkg::BIT_PSE] && $fell(func[0]) |=> ##1 (!o_first_activity_pin_n)[*3])
        else $error("stretch did not hold");
    chk_wake_func: assert property (
        i_wake_rx && sel_q[0][led_status_pkg::BIT_WAKE] |=> func[0])
        else $error("wake packet not shown");
    chk_second_activity_pin_level: assert property (
        ##1 o_second_activity_pin == ($past(led_on[1]) ~^ $past(sel_q[1][led_status_pkg::BIT_INVERT])))
        else $error("second LED level wrong");
    chk_addr_filter: assert property (
        sel_q[0] == 16'h0024 && !i_rx_addr_match |-> !func[0])
        else $error("receive not filtered");

    // read data stands one cycle only, so stale words never leak
    chk_rd_data_idle: assert property (
        !i_rd_en |=> o_rd_data == 16'h0000)
        else $error("read data not cleared");

    // link pin follows the masked link state
    chk_link_pin_lit: assert property (
        link_on |=> !o_link_indicator_pin_n)
        else $error("link LED not lit");
    chk_link_pin_dark: assert property (
        !i_link_pass |=> o_link_indicator_pin_n)
        else $error("link LED lit without link");

    // full-duplex link function per port
    chk_tp_fdl_func: assert property (
        port_tp && i_link_pass && dup_en && sel_q[0][led_status_pkg::BIT_FDLS] |-> func[0])
        else $error("twisted pair duplex link not shown");
    chk_tp_fdl_off: assert property (
        port_tp && !i_link_pass |-> !fdl_status)
        else $error("duplex link shown without link pass");
    chk_aui_fdl_off: assert property (
        port_aui && !aui_dup |-> !fdl_status)
        else $error("attachment duplex link shown wrongly");
    chk_general_serial_port_fdl_on: assert property (
        port_general_serial_port && dup_en && sel_q[0][led_status_pkg::BIT_FDLS] |-> func[0])
        else $error("serial duplex link not shown");

    // each enabled source reaches the OR
    chk_pol_func: assert property (
        sel_q[0][led_status_pkg::BIT_POL] && i_rx_pol_good |-> func[0])
        else $error("polarity not shown");
    chk_rx_func: assert property (
        sel_q[0][led_status_pkg::BIT_RCV] && !sel_q[0][led_status_pkg::BIT_ADDR_M] && i_rx_act |-> func[0])
        else $error("receive activity not shown");
    chk_rx_match_pass: assert property (
        sel_q[0][led_status_pkg::BIT_RCV] && i_rx_act && i_rx_addr_match |-> func[0])
        else $error("matched receive not shown");
    chk_jab_func: assert property (
        sel_q[0][led_status_pkg::BIT_JAB] && i_jabber |-> func[0])
        else $error("jabber not shown");
    chk_col_func: assert property (
        sel_q[0][led_status_pkg::BIT_COL] && i_collision |-> func[0])
        else $error("collision not shown");
    chk_first_activity_pin_pin_follow: assert property (
        func[0] |=> ##1 !o_first_activity_pin_n)
        else $error("first LED not lit");

    // second selector read-back and pin level
    chk_second_activity_pin_rsvd_zero: assert property (
        s_rd_second_activity_pin |=> !o_rd_data[6] && o_rd_data[13:10] == 4'h0)
        else $error("second selector reserved bits not zero");
    chk_second_activity_pin_state_bit: assert property (
        s_rd_second_activity_pin |=> o_rd_data[led_status_pkg::BIT_OUT_STATE] == $past(func[1]))
        else $error("second output state bit wrong");
    chk_second_activity_pin_low_on: assert property (
        func[1] ##1 !sel_q[1][led_status_pkg::BIT_INVERT] |=> !o_second_activity_pin)
        else $error("second LED not driven low");
    chk_second_activity_pin_high_on: assert property (
        func[1] ##1 sel_q[1][led_status_pkg::BIT_INVERT] |=> o_second_activity_pin)
        else $error("second LED not driven high");

    // wake latch holds while any selector enables it
    chk_wake_held: assert property (
        wake_seen_q && !wake_clr |=> wake_seen_q)
        else $error("wake indication lost");

endmodule : led_status_ctrl

/* tb/led_panel.sv */
// Purpose : model of the lamp circuitry hung on the three status pins
// Assumes : each lamp sits between supply and its pin, lit on a low pin
// Notes   : the second lamp is wired the same way whatever the invert bit says
`timescale 1ns/1ps
module led_panel (
    // pins from the block
    input  wire logic i_link_pin_n,
    input  wire logic i_first_pin_n,
    input  wire logic i_second_pin,
    // lamp states
    output logic      o_link_lit,
    output logic      o_first_lit,
    output logic      o_second_lit
);
    // current flows only while the pin sinks it
    assign o_link_lit   = ~i_link_pin_n;
    assign o_first_lit  = ~i_first_pin_n;
    // a set invert bit therefore lights this lamp on bad polarity
    assign o_second_lit = ~i_second_pin;
endmodule : led_panel

/* tb/tb_top.sv */
// Purpose : self-checking bench for the status LED block
// Assumes : short stretch count so hold times stay visible
// Notes   : all inputs driven by non-blocking assignment on the rising edge
`timescale 1ns/1ps
module tb_top;
    localparam int SC    = 8;    // stretch length in the bench
    localparam int LIMIT = 6000; // cycle ceiling for a hang
    logic        ref_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic [3:0]  addr       = 4'h0;
    logic [15:0] wr_data    = 16'h0000;
    logic        wr_en      = 1'b0;
    logic        rd_en      = 1'b0;
    logic [15:0] rd_data;
    logic [1:0]  port_sel   = 2'h0;
    logic        link_pass  = 1'b0;
    logic        addr_match = 1'b0;
    logic        wake       = 1'b0;
    logic        led3_fdls  = 1'b0;
    logic [4:0]  src        = 5'h00; // tx, pol, rx, jab, col from msb
    logic        link_n, first_n, second_pin;
    logic        link_lit, first_lit, second_lit;
    logic        fd;
    logic        mask;
    int          fails    = 0;
    int          n_checks = 0;
    int          cycles   = 0;
    int          n;

    always #5 ref_clk = ~ref_clk;

    led_status_ctrl #(.STRETCH_CYCLES(SC)) dut (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wr_data),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_port_sel(port_sel),
        .i_link_pass(link_pass), .i_rx_act(src[2]), .i_rx_addr_match(addr_match),
        .i_tx_act(src[4]), .i_rx_pol_good(src[3]), .i_jabber(src[1]), .i_collision(src[0]),
        .i_wake_rx(wake), .i_led3_fdls_en(led3_fdls), .o_link_indicator_pin_n(link_n),
        .o_first_activity_pin_n(first_n), .o_second_activity_pin(second_pin));

    led_panel panel (.i_link_pin_n(link_n), .i_first_pin_n(first_n), .i_second_pin(second_pin),
        .o_link_lit(link_lit), .o_first_lit(first_lit), .o_second_lit(second_lit));

    // ************************************
    // bus tasks and compare
    // ************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 check(rd_data, exp);
    endtask : rd

    // counts cycles with the first lamp lit
    task automatic count_lit(output int cnt);
        cnt = 0;
        repeat (24) begin
            @(posedge ref_clk);
            #1 if (first_lit) cnt++;
        end
    endtask : count_lit

    task automatic finish_test();
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            $display("ERROR %0t cycle limit reached", $time);
            finish_test();
        end
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // reset selectors, duplex config, unmapped index
        rd(4'h1, 16'h0084);
        rd(4'h2, 16'h0088);
        rd(4'h3, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h0, 16'h0000);
        // reset selector lights on receive, stretched
        @(posedge ref_clk) src <= 5'h04;
        rd(4'h1, 16'h8084);
        check({15'h0, first_lit}, 16'h0001);
        @(posedge ref_clk) src <= 5'h00;
        // read-only bits drop on write
        wr(4'h1, 16'h83bf);
        rd(4'h1, 16'h03bf);
        wr(4'h2, 16'hc3bf);
        rd(4'h2, 16'h43bf);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0000);
        // each source alone, then every other source with it disabled
        for (int k = 0; k < 5; k++) begin
            wr(4'h1, 16'h0001 << k);
            @(posedge ref_clk) src <= 5'h01 << k;
            rd(4'h1, 16'h8000 | (16'h0001 << k));
            check({15'h0, first_lit}, 16'h0001);
            @(posedge ref_clk) src <= ~(5'h01 << k);
            rd(4'h1, 16'h0001 << k);
            check({15'h0, first_lit}, 16'h0000);
        end
        @(posedge ref_clk) src <= 5'h14;
        wr(4'h1, 16'h0014);
        rd(4'h1, 16'h8014);
        // receive limited to address matches
        @(posedge ref_clk) src <= 5'h04;
        wr(4'h1, 16'h0024);
        rd(4'h1, 16'h0024);
        @(posedge ref_clk) addr_match <= 1'b1;
        rd(4'h1, 16'h8024);
        @(posedge ref_clk) src <= 5'h00;
        // one-cycle transmit pulse, stretch on and off
        wr(4'h1, 16'h0090);
        @(posedge ref_clk) src <= 5'h10;
        @(posedge ref_clk) src <= 5'h00;
        count_lit(n);
        check(16'(n >= SC && n <= SC + 2), 16'h0001);
        wr(4'h1, 16'h0010);
        @(posedge ref_clk) src <= 5'h10;
        @(posedge ref_clk) src <= 5'h00;
        count_lit(n);
        check(16'(n), 16'h0001);
        // wake packet latch
        wr(4'h1, 16'h0200);
        @(posedge ref_clk) wake <= 1'b1;
        @(posedge ref_clk) wake <= 1'b0;
        rd(4'h1, 16'h8200);
        check({15'h0, first_lit}, 16'h0001);
        wr(4'h1, 16'h0000);
        wr(4'h1, 16'h0200);
        rd(4'h1, 16'h0200);
        // full-duplex indication and link masking over every port
        @(posedge ref_clk) link_pass <= 1'b1;
        wr(4'h1, 16'h0100);
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge ref_clk) port_sel <= 2'(p);
                wr(4'h3, 16'(c));
                fd   = (p == 0) ? c[0] : (p == 1) ? (c[0] & c[1]) : (p == 2) ? c[0] : 1'b0;
                mask = (p == 0) && c[0] && !c[1];
                rd(4'h1, {fd, 15'h0100});
                rd(4'h0, {!mask, 15'h0});
                check({15'h0, link_lit}, {15'h0, !mask});
            end
        end
        // third selector's enable masks the link status bit too
        wr(4'h1, 16'h0000);
        @(posedge ref_clk) port_sel <= 2'h0;
        wr(4'h3, 16'h0001);
        rd(4'h0, 16'h8000);
        @(posedge ref_clk) led3_fdls <= 1'b1;
        rd(4'h0, 16'h0000);
        @(posedge ref_clk) led3_fdls <= 1'b0;
        @(posedge ref_clk) link_pass <= 1'b0;
        rd(4'h0, 16'h0000);
        // second pin level against polarity and invert
        @(posedge ref_clk) src <= 5'h08;
        wr(4'h2, 16'h0008);
        rd(4'h2, 16'h8008);
        check({15'h0, second_lit}, 16'h0001);
        wr(4'h2, 16'h4008);
        rd(4'h2, 16'hc008);
        check({15'h0, second_lit}, 16'h0000);
        @(posedge ref_clk) src <= 5'h00;
        rd(4'h2, 16'h4008);
        check({15'h0, second_lit}, 16'h0001);
        wr(4'h2, 16'h0000);
        rd(4'h2, 16'h0000);
        check({15'h0, second_lit}, 16'h0000);
        finish_test();
    end
endmodule : tb_top
